// file: hdl/system_tick_timer.sv
// System tick timer: 24-bit down counter with reload, behind AXI4-Lite.
// Assumes osc_tick is a one-cycle pulse per oscillator period, already
// chosen by the clock generator's oscillator_select, synchronous to aclk.
//
// Behaviour
// - Flag shows zero reached since last read.
// - A read of control clears the flag, unless zero is reached in that cycle.
// - Bit 2 picks reference or CPU clock.
// - Bit 1 lets zero pend tick exception.
// - Enabling loads reload value and starts counting.
// - Reload holds 24 bits, copied at zero.
// - Current value reads live count, upper zero.
// - Any write to current clears counter.
// - Writing current also clears the flag.
// - Calibration bit 31 shows reference absence.
// - Calibration bit 30 shows inexact calibration.
// - Calibration low field reads ten-ms constant.
// - Reference tick is oscillator divided by 32.
module system_tick_timer #(
  parameter logic REF_ABSENT = 1'b0,
  parameter logic CAL_INEXACT = 1'b0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic osc_tick,
  input wire logic [tick_timer_pkg::ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [tick_timer_pkg::ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic tick_pend,
  output logic irq
);

  function automatic tick_timer_pkg::reg_sel_t decode(
    input logic [tick_timer_pkg::ADDR_W-1:0] a
  );
    if (a[11:2] == tick_timer_pkg::OFF_CTRL[11:2]) begin
      decode = tick_timer_pkg::SEL_CTRL;
    end else if (a[11:2] == tick_timer_pkg::OFF_RELOAD[11:2]) begin
      decode = tick_timer_pkg::SEL_RELOAD;
    end else if (a[11:2] == tick_timer_pkg::OFF_CURRENT[11:2]) begin
      decode = tick_timer_pkg::SEL_CURRENT;
    end else if (a[11:2] == tick_timer_pkg::OFF_CAL[11:2]) begin
      decode = tick_timer_pkg::SEL_CAL;
    end else if (a[11:2] == tick_timer_pkg::OFF_IRQ_STATUS[11:2]) begin
      decode = tick_timer_pkg::SEL_IRQ_STATUS;
    end else if (a[11:2] == tick_timer_pkg::OFF_IRQ_MASK[11:2]) begin
      decode = tick_timer_pkg::SEL_IRQ_MASK;
    end else begin
      decode = tick_timer_pkg::SEL_NONE;
    end
  endfunction

  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] data,
    input logic [3:0] strb
  );
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        merge[8*i +: 8] = data[8*i +: 8];
      end
    end
  endfunction

  // Write channel holding registers; the address and data are taken in
  // either order and the write is carried out once both are present.
  logic [tick_timer_pkg::ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_go;
  tick_timer_pkg::reg_sel_t wr_sel;
  tick_timer_pkg::reg_sel_t rd_sel;
  logic rd_go;

  tick_timer_pkg::ctrl_t ctrl;
  tick_timer_pkg::ctrl_t next_ctrl;
  logic [23:0] reload;
  logic [23:0] current;
  logic count_flag;
  logic irq_status;
  logic irq_mask;
  logic [4:0] div_cnt;
  logic ref_tick;
  logic tick;
  logic zero_hit;
  logic wr_cur;
  logic rd_ctrl;
  logic en_load;
  logic [31:0] ctrl_word;
  logic [31:0] merged;
  logic [31:0] reload_merged;

  assign wr_go = !awready && !wready && !bvalid;
  assign wr_sel = decode(aw_addr);
  assign rd_go = arvalid && arready;
  assign rd_sel = decode(araddr);
  assign wr_cur = wr_go && (wr_sel == tick_timer_pkg::SEL_CURRENT);
  assign rd_ctrl = rd_go && (rd_sel == tick_timer_pkg::SEL_CTRL);

  always_comb begin
    ctrl_word = tick_timer_pkg::WORD_ZERO;
    ctrl_word[tick_timer_pkg::BIT_ENABLE] = ctrl.enable;
    ctrl_word[tick_timer_pkg::BIT_EXC_REQ] = ctrl.exc_req;
    ctrl_word[tick_timer_pkg::BIT_CLK_SEL] = ctrl.clk_sel;
    ctrl_word[tick_timer_pkg::BIT_FLAG] = count_flag;
  end

  assign merged = merge(ctrl_word, w_data, w_strb);
  assign reload_merged = merge({8'h00, reload}, w_data, w_strb);

  always_comb begin
    next_ctrl.enable = merged[tick_timer_pkg::BIT_ENABLE];
    next_ctrl.exc_req = merged[tick_timer_pkg::BIT_EXC_REQ];
    next_ctrl.clk_sel = merged[tick_timer_pkg::BIT_CLK_SEL];
  end

  // Only a rising enable loads the counter, so rewriting the other
  // control bits while running does not restart the period.
  assign en_load = wr_go && (wr_sel == tick_timer_pkg::SEL_CTRL)
    && next_ctrl.enable && !ctrl.enable;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      aw_addr <= '0;
    end else if (awvalid && awready) begin
      awready <= 1'b0;
      aw_addr <= awaddr;
    end else if (wr_go) begin
      awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready <= 1'b1;
      w_data <= tick_timer_pkg::WORD_ZERO;
      w_strb <= 4'h0;
    end else if (wvalid && wready) begin
      wready <= 1'b0;
      w_data <= wdata;
      w_strb <= wstrb;
    end else if (wr_go) begin
      wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= tick_timer_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid <= 1'b1;
      if (wr_sel == tick_timer_pkg::SEL_NONE) begin
        bresp <= tick_timer_pkg::RESP_SLVERR;
      end else begin
        bresp <= tick_timer_pkg::RESP_OKAY;
      end
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= tick_timer_pkg::WORD_ZERO;
      rresp <= tick_timer_pkg::RESP_OKAY;
    end else if (rd_go) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rresp <= tick_timer_pkg::RESP_OKAY;
      rdata <= tick_timer_pkg::WORD_ZERO;
      if (rd_sel == tick_timer_pkg::SEL_CTRL) begin
        rdata <= ctrl_word;
      end else if (rd_sel == tick_timer_pkg::SEL_RELOAD) begin
        rdata[23:0] <= reload;
      end else if (rd_sel == tick_timer_pkg::SEL_CURRENT) begin
        rdata[23:0] <= current;
      end else if (rd_sel == tick_timer_pkg::SEL_CAL) begin
        rdata[tick_timer_pkg::BIT_REFERENCE_ABSENT_INDICATOR] <= REF_ABSENT;
        rdata[tick_timer_pkg::BIT_INEXACT] <= CAL_INEXACT;
        rdata[23:0] <= tick_timer_pkg::TEN_MS_VALUE;
      end else if (rd_sel == tick_timer_pkg::SEL_IRQ_STATUS) begin
        rdata[0] <= irq_status;
      end else if (rd_sel == tick_timer_pkg::SEL_IRQ_MASK) begin
        rdata[0] <= irq_mask;
      end else begin
        rresp <= tick_timer_pkg::RESP_SLVERR;
      end
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= tick_timer_pkg::CTRL_RESET;
    end else if (wr_go && (wr_sel == tick_timer_pkg::SEL_CTRL)) begin
      ctrl <= next_ctrl;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reload <= tick_timer_pkg::CNT_ZERO;
    end else if (wr_go && (wr_sel == tick_timer_pkg::SEL_RELOAD)) begin
      reload <= reload_merged[23:0];
    end
  end

  // The oscillator pulses are counted modulo 32 to form the reference.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt <= 5'h00;
    end else if (osc_tick) begin
      div_cnt <= div_cnt + 5'h01;
    end
  end

  assign ref_tick = osc_tick && (div_cnt == tick_timer_pkg::REF_DIV_LAST);
  assign tick = ctrl.enable && (ctrl.clk_sel || ref_tick);
  assign zero_hit = tick && (current == tick_timer_pkg::CNT_ONE) && !wr_cur;

  // A write to the current value wins over a tick in the same cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      current <= tick_timer_pkg::CNT_ZERO;
    end else if (wr_cur) begin
      current <= tick_timer_pkg::CNT_ZERO;
    end else if (en_load) begin
      current <= reload;
    end else if (tick) begin
      if (current == tick_timer_pkg::CNT_ZERO) begin
        current <= reload;
      end else begin
        current <= current - tick_timer_pkg::CNT_ONE;
      end
    end
  end

  // The flag is set in the cycle the count goes from one to zero; a set
  // that meets a clearing read wins, so no event is lost; a current write suppresses the set.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_flag <= 1'b0;
    end else if (zero_hit) begin
      count_flag <= 1'b1;
    end else if (rd_ctrl || wr_cur) begin
      count_flag <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_pend <= 1'b0;
    end else begin
      tick_pend <= zero_hit && ctrl.exc_req;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= 1'b0;
    end else if (zero_hit) begin
      irq_status <= 1'b1;
    end else if (wr_go && (wr_sel == tick_timer_pkg::SEL_IRQ_STATUS)
                 && w_strb[0] && w_data[0]) begin
      irq_status <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask <= 1'b0;
    end else if (wr_go && (wr_sel == tick_timer_pkg::SEL_IRQ_MASK) && w_strb[0]) begin
      irq_mask <= w_data[0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_status && irq_mask;
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_flag_set: assert property (zero_hit |=> count_flag)
    else $error("flag not set after reaching zero");

  a_flag_read_clear: assert property (rd_ctrl && !zero_hit |=> !count_flag)
    else $error("control read did not clear flag");

  a_flag_write_clear: assert property (wr_cur |=> !count_flag)
    else $error("current write did not clear flag");

  a_current_clear: assert property (wr_cur |=> current == 24'h000000)
    else $error("current write did not clear counter");

  a_enable_load: assert property (en_load && !wr_cur |=> current == $past(reload))
    else $error("enable did not load reload value");

  a_zero_reload: assert property (
    tick && current == 24'h000000 && !wr_cur && !en_load |=> current == $past(reload)
  )
    else $error("counter did not reload after zero");

  a_count_down: assert property (
    tick && current != 24'h000000 && !wr_cur && !en_load
    |=> current == $past(current) - 24'h000001
  )
    else $error("counter did not decrement");

  a_count_hold: assert property (
    !ctrl.enable && !wr_cur && !en_load |=> $stable(current)
  )
    else $error("disabled counter moved");

  a_ref_select: assert property (
    ctrl.enable && !ctrl.clk_sel && !ref_tick && !wr_cur && !en_load |=> $stable(current)
  )
    else $error("counter moved without reference tick");

  a_ref_div: assert property (ref_tick |=> !ref_tick [*8])
    else $error("reference ticks too close");

  a_pend_gate: assert property (zero_hit |=> tick_pend == $past(ctrl.exc_req))
    else $error("tick exception gating wrong");

  a_cal_read: assert property (
    rd_go && rd_sel == tick_timer_pkg::SEL_CAL
    |=> rdata == {REF_ABSENT, CAL_INEXACT, 6'h00, 24'h0009c4}
  )
    else $error("calibration read wrong");

  a_ctrl_reserved: assert property (
    rd_ctrl |=> rdata[31:17] == 15'h0000 && rdata[15:3] == 13'h0000
  )
    else $error("reserved control bits not zero");

  a_cur_read: assert property (
    rd_go && rd_sel == tick_timer_pkg::SEL_CURRENT
    |=> rdata == {8'h00, $past(current)}
  )
    else $error("current read not live count");

  c_zero_pend: cover property (zero_hit && ctrl.exc_req ##1 tick_pend);
  c_read_flag: cover property (count_flag ##[1:20] rd_ctrl);
  c_ref_count: cover property (ctrl.enable && !ctrl.clk_sel && ref_tick);
  c_set_beats_clear: cover property (zero_hit && rd_ctrl);

endmodule // system_tick_timer

// file: hdl/tick_timer_pkg.sv
// Constants, field positions and types of the system tick timer.
// Assumes an AXI4-Lite master with 32-bit data and word-aligned offsets.
package tick_timer_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned CNT_W = 24;

  localparam logic [11:0] OFF_CTRL = 12'h010;
  localparam logic [11:0] OFF_RELOAD = 12'h014;
  localparam logic [11:0] OFF_CURRENT = 12'h018;
  localparam logic [11:0] OFF_CAL = 12'h01c;
  localparam logic [11:0] OFF_IRQ_STATUS = 12'h020;
  localparam logic [11:0] OFF_IRQ_MASK = 12'h024;

  localparam int unsigned BIT_ENABLE = 0;
  localparam int unsigned BIT_EXC_REQ = 1;
  localparam int unsigned BIT_CLK_SEL = 2;
  localparam int unsigned BIT_FLAG = 16;
  localparam int unsigned BIT_REFERENCE_ABSENT_INDICATOR = 31;
  localparam int unsigned BIT_INEXACT = 30;

  localparam logic [23:0] TEN_MS_VALUE = 24'h0009c4;
  localparam logic [5:0] REF_DIV = 6'h20;
  localparam logic [4:0] REF_DIV_LAST = 5'h1f;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam logic [31:0] WORD_ZERO = 32'h00000000;
  localparam logic [23:0] CNT_ZERO = 24'h000000;
  localparam logic [23:0] CNT_ONE = 24'h000001;

  typedef struct packed {
    logic clk_sel;
    logic exc_req;
    logic enable;
  } ctrl_t;

  localparam ctrl_t CTRL_RESET = '{clk_sel: 1'b0, exc_req: 1'b0, enable: 1'b0};

  typedef enum logic [2:0] {
    SEL_NONE = 3'b000,
    SEL_CTRL = 3'b001,
    SEL_RELOAD = 3'b010,
    SEL_CURRENT = 3'b011,
    SEL_CAL = 3'b100,
    SEL_IRQ_STATUS = 3'b101,
    SEL_IRQ_MASK = 3'b110
  } reg_sel_t;

endpackage

// file: test/testbench.sv
// Self-checking bench for the system tick timer, driven over AXI4-Lite.
// Allows any answer latency; only the watchdog ends a wait that never ends.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic aclk, aresetn, osc_tick;
  logic [11:0] awaddr, araddr;
  logic [2:0] awprot, arprot;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, tick_pend, irq;
  logic [31:0] wdata, rdata, rd_word;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  int n_mismatch, checks_done, pend_count;

  system_tick_timer DUT (
    .aclk(aclk), .aresetn(aresetn), .osc_tick(osc_tick),
    .awaddr(awaddr), .awprot(awprot), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arprot(arprot), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .tick_pend(tick_pend), .irq(irq)
  );

  always #2.5 aclk = ~aclk;

  always @(posedge aclk) begin
    if (tick_pend === 1'b1) begin
      pend_count++;
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Both tasks start and end just after a rising edge; bready and rready stay high.
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    resp = bresp;
  endtask

  task automatic axi_read(input logic [11:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rd_word = rdata;
    resp = rresp;
  endtask

  task automatic wchk(input logic [11:0] a, input logic [31:0] d);
    axi_write(a, d);
    chk("bresp", {30'h0, tick_timer_pkg::RESP_OKAY}, {30'h0, resp});
  endtask

  task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
    axi_read(a);
    chk("rresp", {30'h0, tick_timer_pkg::RESP_OKAY}, {30'h0, resp});
    chk(nm, e, rd_word);
  endtask

  task automatic osc_pulses(input int n);
    repeat (n) begin
      osc_tick <= 1'b1;
      @(posedge aclk);
      osc_tick <= 1'b0;
      @(posedge aclk);
    end
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    #100us;
    n_mismatch++;
    $display("watchdog expired");
    final_report();
  end

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    osc_tick = 1'b0;
    awaddr = 12'h000;
    araddr = 12'h000;
    awprot = 3'h0;
    arprot = 3'h0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    arvalid = 1'b0;
    wdata = 32'h00000000;
    wstrb = 4'h0;
    bready = 1'b1;
    rready = 1'b1;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rchk("ctrl reset", tick_timer_pkg::OFF_CTRL, 32'h00000000);
    rchk("calibration", tick_timer_pkg::OFF_CAL, 32'h000009c4);
    rchk("reload reset", tick_timer_pkg::OFF_RELOAD, 32'h00000000);
    rchk("current reset", tick_timer_pkg::OFF_CURRENT, 32'h00000000);
    rchk("mask reset", tick_timer_pkg::OFF_IRQ_MASK, 32'h00000000);
    axi_read(12'h030);
    chk("unmapped rresp", {30'h0, tick_timer_pkg::RESP_SLVERR}, {30'h0, resp});
    chk("unmapped rdata", 32'h00000000, rd_word);
    axi_write(12'h030, 32'hffffffff);
    chk("unmapped bresp", {30'h0, tick_timer_pkg::RESP_SLVERR}, {30'h0, resp});
    $display("test reset and map done");

    // The divider has seen no oscillator pulse since reset, so its phase is known.
    wchk(tick_timer_pkg::OFF_RELOAD, 32'h00000003);
    wchk(tick_timer_pkg::OFF_CTRL, 32'h00000003);
    rchk("load on enable", tick_timer_pkg::OFF_CURRENT, 32'h00000003);
    osc_pulses(31);
    rchk("no tick before 32", tick_timer_pkg::OFF_CURRENT, 32'h00000003);
    osc_pulses(1);
    rchk("tick at 32", tick_timer_pkg::OFF_CURRENT, 32'h00000002);
    osc_pulses(64);
    rchk("count to zero", tick_timer_pkg::OFF_CURRENT, 32'h00000000);
    chk("tick_pend pulses", 32'h1, pend_count);
    rchk("flag set", tick_timer_pkg::OFF_CTRL, 32'h00010003);
    rchk("flag cleared by read", tick_timer_pkg::OFF_CTRL, 32'h00000003);
    osc_pulses(32);
    rchk("reload after zero", tick_timer_pkg::OFF_CURRENT, 32'h00000003);
    $display("test reference count done");

    rchk("irq status", tick_timer_pkg::OFF_IRQ_STATUS, 32'h00000001);
    chk("irq masked", 32'h0, {31'h0, irq});
    wchk(tick_timer_pkg::OFF_IRQ_MASK, 32'h00000001);
    repeat (3) @(posedge aclk);
    chk("irq unmasked", 32'h1, {31'h0, irq});
    wchk(tick_timer_pkg::OFF_IRQ_STATUS, 32'h00000001);
    repeat (3) @(posedge aclk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    rchk("irq status cleared", tick_timer_pkg::OFF_IRQ_STATUS, 32'h00000000);
    $display("test interrupt done");

    osc_pulses(96);
    wchk(tick_timer_pkg::OFF_CURRENT, 32'hffffffff);
    rchk("current write clears", tick_timer_pkg::OFF_CURRENT, 32'h00000000);
    rchk("write clears flag", tick_timer_pkg::OFF_CTRL, 32'h00000003);
    wchk(tick_timer_pkg::OFF_IRQ_STATUS, 32'h00000001);
    $display("test current clear done");

    wchk(tick_timer_pkg::OFF_RELOAD, 32'hff000003);
    rchk("reload width", tick_timer_pkg::OFF_RELOAD, 32'h00000003);
    wchk(tick_timer_pkg::OFF_CTRL, 32'h00000005);
    repeat (20) @(posedge aclk);
    axi_read(tick_timer_pkg::OFF_CURRENT);
    chk("live upper zero", 32'h0, {8'h0, rd_word[31:24]});
    chk("live in range", 32'h1, {31'h0, rd_word[23:0] <= 24'h000003});
    chk("no pend when off", 32'h2, pend_count);
    rchk("cpu clock flag", tick_timer_pkg::OFF_CTRL, 32'h00010005);
    wchk(tick_timer_pkg::OFF_CTRL, 32'h00000000);
    axi_read(tick_timer_pkg::OFF_CURRENT);
    repeat (10) @(posedge aclk);
    rchk("stopped when off", tick_timer_pkg::OFF_CURRENT, rd_word);
    wchk(tick_timer_pkg::OFF_CTRL, 32'hffffffff);
    axi_read(tick_timer_pkg::OFF_CTRL);
    chk("reserved zero", 32'h00000007, rd_word & 32'hfffeffff);
    wchk(tick_timer_pkg::OFF_CTRL, 32'h00000000);
    $display("test cpu clock done");

    // Software loads calibration minus one, so one period is exactly that many plus one ticks.
    axi_read(tick_timer_pkg::OFF_CAL);
    wchk(tick_timer_pkg::OFF_RELOAD, {8'h00, rd_word[23:0] - 24'h000001});
    wchk(tick_timer_pkg::OFF_CTRL, 32'h00000005);
    axi_read(tick_timer_pkg::OFF_CTRL);
    repeat (2000) @(posedge aclk);
    rchk("no zero before period", tick_timer_pkg::OFF_CTRL, 32'h00000005);
    repeat (600) @(posedge aclk);
    rchk("zero within period", tick_timer_pkg::OFF_CTRL, 32'h00010005);
    wchk(tick_timer_pkg::OFF_CTRL, 32'h00000000);
    $display("test multi-shot done");
    final_report();
  end
endmodule // testbench
